// file: hdl/asu_map.svh
`ifndef ASU_MAP_SVH
`define ASU_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ASU_OFS_AC0_LO   8'h00
`define ASU_OFS_AC0_HI   8'h04
`define ASU_OFS_AC1_LO   8'h08
`define ASU_OFS_AC1_HI   8'h0c
`define ASU_OFS_TAX      8'h10
`define ASU_OFS_TCNT     8'h14
`define ASU_OFS_CTRL     8'h18
`define ASU_OFS_CMD      8'h1c
`define ASU_OFS_STAT     8'h20

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ASU_CMD_OP       2:0
`define ASU_CMD_TAX      3
`define ASU_CMD_SRC      4
`define ASU_CMD_DGIVEN   5
`define ASU_CMD_DST      6
`define ASU_CMD_IMM      13:8
`define ASU_CTRL_BITS    3:0
`define ASU_STAT_CARRY   0
`define ASU_STAT_ACOV    2:1

// ----------------------------------------------------------------
// Constants
// ----------------------------------------------------------------
`define ASU_CNT_MAX      16'h001f
`define ASU_CNT_MIN      16'hffe0
`define ASU_SAT32_POS    40'h007fffffff
`define ASU_SAT32_NEG    40'hff80000000
`define ASU_SAT40_POS    40'h7fffffffff
`define ASU_SAT40_NEG    40'h8000000000
`define ASU_CNT_PLUS1    6'h01
`define ASU_CNT_MINUS1   6'h3f

`endif

// file: hdl/asu_pkg.sv
`include "asu_map.svh"

package asu_pkg;

    typedef enum logic [2:0] {
        ASU_LOG_IMM   = 3'b000,
        ASU_LOG_REG   = 3'b001,
        ASU_LOG_L1    = 3'b010,
        ASU_LOG_R1    = 3'b011,
        ASU_ARI_REG   = 3'b100,
        ASU_ARI_REG_C = 3'b101,
        ASU_ARI_IMM   = 3'b110,
        ASU_ARI_IMM_C = 3'b111
    } asu_op_e;

    typedef struct packed {
        logic legacy_compat_mode;
        logic d_unit_saturate_enable;
        logic sign_ext_mode;
        logic wide_mode_flag;
    } asu_ctrl_s;

    typedef struct packed {
        logic [39:0] ac0;
        logic [39:0] ac1;
        logic [15:0] addr_or_temp_register;
        logic [15:0] tcnt;
        asu_ctrl_s   ctrl;
        logic        carry;
        logic [1:0]  acov;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } asu_state_s;

endpackage

// file: hdl/asu_top.sv
`timescale 1ns/1ps
`include "asu_map.svh"

// Operation
// - Immediate logical shift, last bit to carry
// - Zero immediate count clears carry
// - Logical shifts on 40 bits, width per mode
// - Accumulator via shifter, register via ALU
// - Narrow left one: carry bit 31, guards zero
// - Left shifts fill bit 0 with zero
// - Right one: zero at top, bit 0 carry
// - Register right one: 16 bits, bit 0 carry
// - Signed register count clamped to -32..31, sets overflow
// - Narrow signed input guards zero or sign
// - Sign position bit 31 or 39
// - Narrow overflow at 31, optional saturation
// - Wide overflow at 39, optional saturation
// - Legacy: signed shifts wide, no overflow handling
// - Legacy count: six bits, -32..-17 folded up by 16
// - Result to destination, else to source
// - Logical register count clamps without overflow
// - Carry variants store last bit, zero clears

module asu_top
    import asu_pkg::*;
(
    input  wire logic        I_CLOCK,
    input  wire logic        I_RST_N,
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [7:0]  I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic      [31:0] O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    output logic             O_CARRY,
    output logic      [1:0]  O_ACOV
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------

    // Returns one-hot register select; all zero means unmapped
    function automatic logic [8:0] reg_sel(input logic [7:0] a);
        logic [8:0] s;
        s = 9'h000;
        case (a)
            `ASU_OFS_AC0_LO: s[0] = 1'b1;
            `ASU_OFS_AC0_HI: s[1] = 1'b1;
            `ASU_OFS_AC1_LO: s[2] = 1'b1;
            `ASU_OFS_AC1_HI: s[3] = 1'b1;
            `ASU_OFS_TAX:    s[4] = 1'b1;
            `ASU_OFS_TCNT:   s[5] = 1'b1;
            `ASU_OFS_CTRL:   s[6] = 1'b1;
            `ASU_OFS_CMD:    s[7] = 1'b1;
            `ASU_OFS_STAT:   s[8] = 1'b1;
            default:         s = 9'h000;
        endcase
        return s;
    endfunction

    // Register count to shift amount; bit 6 flags a clamp
    function automatic logic [6:0] count_decode(input logic [15:0] t,
                                                input logic        legacy);
        logic [5:0] v;
        logic       cl;
        v  = t[5:0];
        cl = 1'b0;
        // Legacy mode reads six bits only, so it never clamps or flags
        if (legacy) begin
            if (v[5] && !v[4]) begin
                v = {v[5], 1'b1, v[3:0]};
            end
        end else if ($signed(t) > $signed(`ASU_CNT_MAX)) begin
            v  = 6'(`ASU_CNT_MAX);
            cl = 1'b1;
        end else if ($signed(t) < $signed(`ASU_CNT_MIN)) begin
            v  = 6'(`ASU_CNT_MIN);
            cl = 1'b1;
        end
        return {cl, v};
    endfunction

    // Magnitude of a 6-bit signed count; -32 gives 32
    function automatic logic [5:0] mag(input logic [5:0] n);
        return n[5] ? 6'(~n + 6'h01) : n;
    endfunction

    // ------------------------------------------------------------
    // Logical shifter, returns {carry, result}
    // ------------------------------------------------------------
    function automatic logic [40:0] log_shift(input logic [39:0] a,
                                              input logic        wide,
                                              input logic [5:0]  n);
        logic [39:0] x;
        logic [79:0] e;
        logic [5:0]  m;
        logic        c;
        logic [39:0] r;
        x = wide ? a : {8'h00, a[31:0]};
        m = mag(n);
        c = 1'b0;
        r = x;
        e = 80'h0;
        // A zero count passes the input through, guards cleared if narrow, and clears carry
        if (n != 6'h00 && !n[5]) begin
            e = {40'h0, x} << m;
            r = e[39:0];
            c = wide ? e[40] : e[32];
            if (!wide) begin
                r[39:32] = 8'h00;
            end
        end else if (n[5]) begin
            // Narrow input has zero guards, so zero enters at bit 31
            e = {x, 40'h0} >> m;
            r = e[79:40];
            c = e[39];
        end
        return {c, r};
    endfunction

    // ------------------------------------------------------------
    // Signed shifter, returns {overflow, carry, result}
    // ------------------------------------------------------------
    function automatic logic [41:0] ari_shift(input logic [39:0] a,
                                              input asu_ctrl_s   k,
                                              input logic [5:0]  n);
        logic [39:0] x;
        logic [79:0] e;
        logic [5:0]  m;
        logic        wide;
        logic        c;
        logic        o;
        logic [39:0] r;
        wide = k.wide_mode_flag | k.legacy_compat_mode;
        if (wide) begin
            x = a;
        end else begin
            x = {k.sign_ext_mode ? {8{a[31]}} : 8'h00, a[31:0]};
        end
        m = mag(n);
        c = 1'b0;
        o = 1'b0;
        r = x;
        e = 80'h0;
        if (n != 6'h00 && !n[5]) begin
            e = {{40{x[39]}}, x} << m;
            r = e[39:0];
            c = wide ? e[40] : e[32];
            // Sign comparison point follows the mode
            if (wide) begin
                o = ~(&e[79:39] | ~|e[79:39]);
            end else begin
                o = ~(&e[79:31] | ~|e[79:31]);
            end
        end else if (n[5]) begin
            e = 80'($signed({x, 40'h0}) >>> m);
            r = e[79:40];
            c = e[39];
            if (!wide) begin
                o = ~(&r[39:31] | ~|r[39:31]);
            end
        end
        // Legacy drops overflow after the shift, so one shifter serves both
        if (k.legacy_compat_mode) begin
            o = 1'b0;
        end
        // Saturation sign comes from the shifter input, not the result
        if (o && k.d_unit_saturate_enable) begin
            if (wide) begin
                r = x[39] ? `ASU_SAT40_NEG : `ASU_SAT40_POS;
            end else begin
                r = x[39] ? `ASU_SAT32_NEG : `ASU_SAT32_POS;
            end
        end
        return {o, c, r};
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // Bus answer, registers and flags share one state word
    asu_state_s  s_q;
    asu_state_s  s_d;

    always_comb begin
        logic [8:0]  sel;
        logic        setup;
        logic        wr;
        asu_op_e     op;
        logic [39:0] src;
        logic        dsti;
        logic [6:0]  cnt;
        logic [40:0] lres;
        logic [41:0] ares;
        logic [5:0]  imm;

        s_d   = s_q;
        sel   = reg_sel(I_PADDR);
        setup = I_PSEL & ~I_PENABLE;
        wr    = I_PSEL & I_PENABLE & I_PWRITE & s_q.pready;
        op    = asu_op_e'(I_PWDATA[`ASU_CMD_OP]);
        src   = I_PWDATA[`ASU_CMD_SRC] ? s_q.ac1 : s_q.ac0;
        dsti  = I_PWDATA[`ASU_CMD_DGIVEN] ? I_PWDATA[`ASU_CMD_DST]
                                          : I_PWDATA[`ASU_CMD_SRC];
        imm   = I_PWDATA[`ASU_CMD_IMM];
        cnt   = count_decode(s_q.tcnt, s_q.ctrl.legacy_compat_mode);
        lres  = 41'h0;
        ares  = 42'h0;

        // ------------------------------------------------------------
        // Bus answer: ready one cycle after setup, no wait states
        // ------------------------------------------------------------
        s_d.pready  = setup;
        s_d.pslverr = setup & ~|sel;
        // Read data is latched at setup and holds until the next setup
        if (setup) begin
            s_d.prdata = 32'h0;
            if (!I_PWRITE) begin
                case (1'b1)
                    sel[0]:  s_d.prdata = s_q.ac0[31:0];
                    sel[1]:  s_d.prdata = {24'h0, s_q.ac0[39:32]};
                    sel[2]:  s_d.prdata = s_q.ac1[31:0];
                    sel[3]:  s_d.prdata = {24'h0, s_q.ac1[39:32]};
                    sel[4]:  s_d.prdata = {16'h0, s_q.addr_or_temp_register};
                    sel[5]:  s_d.prdata = {16'h0, s_q.tcnt};
                    sel[6]:  s_d.prdata = {28'h0, s_q.ctrl};
                    sel[8]:  s_d.prdata = {29'h0, s_q.acov, s_q.carry};
                    default: s_d.prdata = 32'h0;
                endcase
            end
        end

        // ------------------------------------------------------------
        // Register writes and command execution
        // ------------------------------------------------------------
        if (wr) begin
            case (1'b1)
                sel[0]: s_d.ac0[31:0]  = I_PWDATA;
                sel[1]: s_d.ac0[39:32] = I_PWDATA[7:0];
                sel[2]: s_d.ac1[31:0]  = I_PWDATA;
                sel[3]: s_d.ac1[39:32] = I_PWDATA[7:0];
                sel[4]: s_d.addr_or_temp_register        = I_PWDATA[15:0];
                sel[5]: s_d.tcnt       = I_PWDATA[15:0];
                sel[6]: s_d.ctrl       = asu_ctrl_s'(I_PWDATA[`ASU_CTRL_BITS]);
                sel[8]: s_d.acov       = s_q.acov & ~I_PWDATA[`ASU_STAT_ACOV];
                default: begin
                end
            endcase

            // Commands are write-only; a read of this word returns zero
            if (sel[7]) begin
                case (op)
                    ASU_LOG_IMM: begin
                        lres = log_shift(src, s_q.ctrl.wide_mode_flag, imm);
                    end
                    ASU_LOG_REG: begin
                        // Clamp flag deliberately unused here
                        lres = log_shift(src, s_q.ctrl.wide_mode_flag,
                                         cnt[5:0]);
                    end
                    ASU_LOG_L1: begin
                        lres = log_shift(src, s_q.ctrl.wide_mode_flag,
                                         `ASU_CNT_PLUS1);
                    end
                    ASU_LOG_R1: begin
                        lres = log_shift(src, s_q.ctrl.wide_mode_flag,
                                         `ASU_CNT_MINUS1);
                    end
                    ASU_ARI_REG, ASU_ARI_REG_C: begin
                        ares = ari_shift(src, s_q.ctrl, cnt[5:0]);
                    end
                    ASU_ARI_IMM, ASU_ARI_IMM_C: begin
                        ares = ari_shift(src, s_q.ctrl, imm);
                    end
                    default: begin
                    end
                endcase

                // Carry and overflow persist unless a command touches them
                if (!op[2]) begin
                    if ((op == ASU_LOG_L1 || op == ASU_LOG_R1) &&
                        I_PWDATA[`ASU_CMD_TAX]) begin
                        // Address-unit path, never touches accumulators
                        if (op == ASU_LOG_L1) begin
                            s_d.carry = s_q.addr_or_temp_register[15];
                            s_d.addr_or_temp_register   = {s_q.addr_or_temp_register[14:0], 1'b0};
                        end else begin
                            s_d.carry = s_q.addr_or_temp_register[0];
                            s_d.addr_or_temp_register   = {1'b0, s_q.addr_or_temp_register[15:1]};
                        end
                    end else begin
                        s_d.carry = lres[40];
                        if (dsti) begin
                            s_d.ac1 = lres[39:0];
                        end else begin
                            s_d.ac0 = lres[39:0];
                        end
                    end
                end else begin
                    if (op == ASU_ARI_REG_C || op == ASU_ARI_IMM_C) begin
                        s_d.carry = ares[40];
                    end
                    if (dsti) begin
                        s_d.ac1 = ares[39:0];
                    end else begin
                        s_d.ac0 = ares[39:0];
                    end
                    // Sticky flag; a set here cannot be lost to a clear
                    if (ares[41] ||
                        (cnt[6] && !op[1] && !s_q.ctrl.legacy_compat_mode)) begin
                        s_d.acov[dsti] = 1'b1;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Reset is sampled on the clock edge; there is no asynchronous path
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Outputs come straight from the state register, never from the bus
    assign O_PRDATA  = s_q.prdata;
    assign O_PREADY  = s_q.pready;
    assign O_PSLVERR = s_q.pslverr;
    assign O_CARRY   = s_q.carry;
    assign O_ACOV    = s_q.acov;

endmodule

// file: tb/asu_properties.sv
`timescale 1ns/1ps
`include "asu_map.svh"
// ------
// Checker
// ------
module asu_properties (
    input wire logic        I_CLOCK,
    input wire logic        I_RST_N,
    input wire logic        I_PSEL,
    input wire logic        I_PENABLE,
    input wire logic        I_PWRITE,
    input wire logic [7:0]  I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic [31:0] O_PRDATA,
    input wire logic        O_PREADY,
    input wire logic        O_PSLVERR,
    input wire logic        O_CARRY,
    input wire logic [1:0]  O_ACOV
);
    logic [3:0]  ctrl_q;
    logic [15:0] tcnt_q;
    logic        acc_w;
    logic [2:0]  op;
    logic        dst;
    logic        big;
    assign acc_w = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;
    assign op    = I_PWDATA[2:0];
    assign dst   = I_PWDATA[5] ? I_PWDATA[6] : I_PWDATA[4];
    assign big   = $signed(tcnt_q) > 16'sd31 || $signed(tcnt_q) < -16'sd32;
    // Shadows of the control and count words, seen only through bus writes
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            ctrl_q <= 4'h0;
            tcnt_q <= 16'h0;
        end else if (acc_w && I_PADDR == `ASU_OFS_CTRL) begin
            ctrl_q <= I_PWDATA[3:0];
        end else if (acc_w && I_PADDR == `ASU_OFS_TCNT) begin
            tcnt_q <= I_PWDATA[15:0];
        end
    end
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_N);
    sequence s_setup; I_PSEL && !I_PENABLE; endsequence
    sequence s_cmd; acc_w && I_PADDR == `ASU_OFS_CMD; endsequence
    property p_ready; s_setup |=> O_PREADY; endproperty
    a_ready: assert property (p_ready) else $error("ready missing after setup");
    property p_ready_cause; O_PREADY |-> $past(I_PSEL && !I_PENABLE); endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("ready without setup");
    property p_unmapped; s_setup ##0 I_PADDR > 8'h20 |=> O_PSLVERR && O_PRDATA == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_imm_zero; s_cmd ##0 (op == 3'h0 && I_PWDATA[13:8] == 6'h0) |=> !O_CARRY;
    endproperty
    a_imm_zero: assert property (p_imm_zero) else $error("carry kept at zero count");
    property p_carry_zero;
        s_cmd ##0 ((op == 3'h5 && tcnt_q == 16'h0) || (op == 3'h7 && I_PWDATA[13:8] == 6'h0))
        |=> !O_CARRY;
    endproperty
    a_carry_zero: assert property (p_carry_zero) else $error("carry kept at zero");
    property p_log_noovf; s_cmd ##0 !op[2] |=> $stable(O_ACOV); endproperty
    a_log_noovf: assert property (p_log_noovf) else $error("logical shift set overflow");
    property p_clamp;
        s_cmd ##0 (op[2:1] == 2'b10 && !ctrl_q[3] && big) |=> O_ACOV[$past(dst)];
    endproperty
    a_clamp: assert property (p_clamp) else $error("clamp without overflow flag");
    property p_legacy; s_cmd ##0 (op[2] && ctrl_q[3]) |=> $stable(O_ACOV); endproperty
    a_legacy: assert property (p_legacy) else $error("overflow touched in legacy");
    property p_sticky;
        $fell(O_ACOV[0]) |-> $past(acc_w && I_PADDR == `ASU_OFS_STAT && I_PWDATA[1]);
    endproperty
    a_sticky: assert property (p_sticky) else $error("overflow flag dropped by itself");
    property p_rst;
        disable iff (1'b0) !I_RST_N |=> !O_PREADY && !O_CARRY && O_ACOV == 2'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule

// file: tb/accumulator_shift_unit_tb.sv
`timescale 1ns/1ps
`include "asu_map.svh"
// ------
// Bench
// ------
module accumulator_shift_unit_tb
    import asu_pkg::*;
;
    typedef struct packed {
        logic [3:0]  k;
        logic [39:0] a;
        logic [15:0] t;
        logic [13:0] cmd;
        logic [39:0] r;
        logic        c;
        logic [1:0]  v;
    } asu_row_s;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        carry;
    logic [1:0]  acov;
    logic [31:0] rdv;
    logic        erv;
    logic [39:0] got;
    int          fails = 0;
    int          checks = 0;
    asu_row_s    rows[17];
    asu_row_s    r;
    always #50 clock = ~clock;
    asu_top dut (.I_CLOCK(clock), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .O_CARRY(carry), .O_ACOV(acov));
    task automatic print_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [39:0] g, input logic [39:0] e);
        checks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH at %0t got 0x%h exp 0x%h", $time, g, e);
        end
    endtask
    // Holds the request until ready is seen; data taken at the access edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1 && n < 16) begin
            @(posedge clock);
            n++;
        end
        if (pready !== 1'b1) begin
            fails++;
            print_verdict();
        end
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdacc(input logic s);
        apb(1'b0, s ? `ASU_OFS_AC1_HI : `ASU_OFS_AC0_HI, 32'h0);
        got[39:32] = rdv[7:0];
        apb(1'b0, s ? `ASU_OFS_AC1_LO : `ASU_OFS_AC0_LO, 32'h0);
        got[31:0] = rdv;
    endtask
    initial begin
        rows = '{
            '{4'h0, 40'h8fe3405678, 16'h0, 14'h0062, 40'h00c680acf0, 1'b1, 2'h0},
            '{4'h0, 40'hff80000003, 16'h0, 14'h0003, 40'h0040000001, 1'b1, 2'h0},
            '{4'h1, 40'h8000000002, 16'h0, 14'h0003, 40'h4000000001, 1'b0, 2'h0},
            '{4'h0, 40'h0, 16'h8001, 14'h000b, 40'h4000, 1'b1, 2'h0},
            '{4'h0, 40'h0, 16'h8001, 14'h000a, 40'h0002, 1'b1, 2'h0},
            '{4'h1, 40'h000000000c, 16'h0, 14'h3c00, 40'h0, 1'b1, 2'h0},
            '{4'h1, 40'h123456789a, 16'h0, 14'h0000, 40'h123456789a, 1'b0, 2'h0},
            '{4'h1, 40'h0000000201, 16'h0040, 14'h0001, 40'h0080000000, 1'b1, 2'h0},
            '{4'h1, 40'h8000000000, 16'hff00, 14'h0004, 40'hffffffff80, 1'b1, 2'h1},
            '{4'h6, 40'h80aa001234, 16'h0005, 14'h0004, 40'hff80000000, 1'b1, 2'h1},
            '{4'h0, 40'hff80000000, 16'hfffc, 14'h0004, 40'h0008000000, 1'b1, 2'h0},
            '{4'h5, 40'h4000000000, 16'h0, 14'h0166, 40'h7fffffffff, 1'b1, 2'h2},
            '{4'hc, 40'h4000000000, 16'h0, 14'h0106, 40'h8000000000, 1'b1, 2'h0},
            '{4'h8, 40'h0000000100, 16'h12ec, 14'h0004, 40'h0000000010, 1'b1, 2'h0},
            '{4'h1, 40'h0000000001, 16'h0, 14'h0005, 40'h0000000001, 1'b0, 2'h0},
            '{4'h1, 40'h0000000003, 16'h0, 14'h3f07, 40'h0000000001, 1'b1, 2'h0},
            '{4'h2, 40'h0080000000, 16'h0, 14'h3c06, 40'hfff8000000, 1'b1, 2'h0}};
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            r = rows[i];
            apb(1'b1, `ASU_OFS_AC0_LO, r.a[31:0]);
            apb(1'b1, `ASU_OFS_AC0_HI, {24'h0, r.a[39:32]});
            apb(1'b1, `ASU_OFS_TAX, {16'h0, r.t});
            apb(1'b1, `ASU_OFS_TCNT, {16'h0, r.t});
            apb(1'b1, `ASU_OFS_CTRL, {28'h0, r.k});
            apb(1'b1, `ASU_OFS_STAT, 32'h6);
            apb(1'b1, `ASU_OFS_CMD, {18'h0, r.cmd});
            @(negedge clock);
            chk(40'(carry), 40'(r.c));
            chk(40'(acov), 40'(r.v));
            if (r.cmd[3] && r.cmd[2:1] == 2'b01) begin
                apb(1'b0, `ASU_OFS_TAX, 32'h0);
                got = 40'(rdv[15:0]);
            end else begin
                rdacc(r.cmd[5] ? r.cmd[6] : r.cmd[4]);
            end
            chk(got, r.r);
            if (r.cmd[5]) begin
                rdacc(1'b0);
                chk(got, r.a);
            end
            $display("row %0d done", i);
        end
        // Unmapped place is refused; the write-only command word reads zero without error
        apb(1'b0, 8'h24, 32'h0);
        chk(40'({erv, rdv}), 40'({1'b1, 32'h0}));
        apb(1'b0, `ASU_OFS_CMD, 32'h0);
        chk(40'({erv, rdv}), 40'h0);
        $display("refusal test done");
        // Largest positive count clamps; clearing one flag leaves the other
        apb(1'b1, `ASU_OFS_TCNT, 32'h7fff);
        apb(1'b1, `ASU_OFS_CTRL, 32'h0);
        apb(1'b1, `ASU_OFS_STAT, 32'h6);
        apb(1'b1, `ASU_OFS_CMD, 32'h25);
        apb(1'b1, `ASU_OFS_CMD, 32'h64);
        @(negedge clock);
        chk(40'(acov), 40'h3);
        apb(1'b1, `ASU_OFS_STAT, 32'h4);
        @(negedge clock);
        chk(40'(acov), 40'h1);
        $display("clamp test done");
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        @(negedge clock);
        chk(40'({carry, acov}), 40'h0);
        rdacc(1'b0);
        chk(got, 40'h0);
        apb(1'b0, `ASU_OFS_CTRL, 32'h0);
        chk(40'(rdv), 40'h0);
        $display("reset test done");
        print_verdict();
    end
endmodule
bind asu_top asu_properties u_props (.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
    .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_CARRY(O_CARRY),
    .O_ACOV(O_ACOV));
